// file: verilog/lgc_cell.sv
// Configurable logic cell: source select, four gates, logic function,
// output polarity and edge flag, set up over a plain register port.
// Assumes sources are synchronous to clk; sequential functions act on clk edges.
//
// Notes on behaviour
// - rise enable sets flag on rising output
// - fall enable sets flag on falling output
// - code 101 is two-input D flop
// - code 100 is D flop, set, reset
// - result invert bit, clears on reset
// - four gate invert bits, kept over reset
// - six-bit source codes, top bits zero
// - bit pairs route inputs into gates
// - unrouted input ignored by gate
// - inverted route feeds complement independently
// - codes 0-39 defined, above reserved
// - gates AND routed inputs, else constant
// - reset clears control, result invert and flag, keeps selects, routes and gate inverts
`timescale 1ns/10ps
module lgc_cell
    import lgc_pkg::*;
#(
    parameter int NUM_SRC = 40
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire lgc_bus_req_type   bus_req,
    output logic [DATA_W-1:0]      rdata,
    input  wire logic [NUM_SRC-1:0] src_in,
    output logic                   cell_result,
    output logic                   cell_irq_flag
);

    // Configuration, not reset
    logic [SRC_W-1:0] input_source_q [4];
    logic [SRC_W-1:0] input_source_d [4];
    logic [7:0]       gate_route_q   [4];
    logic [7:0]       gate_route_d   [4];
    logic [3:0]       gate_invert_q;
    logic [3:0]       gate_invert_d;

    // Reset state
    logic [7:0]  cell_control_q;
    logic [7:0]  cell_control_d;
    logic        result_invert_q;
    logic        result_invert_d;
    logic        state_q;
    logic        state_d;
    logic        gate_one_prev_q;
    logic        result_q;
    logic        result_d;
    logic        result_prev_q;
    logic        flag_q;
    logic        flag_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;

    logic [3:0]   selected;
    logic [3:0]   gate;
    logic         func;
    logic         clk_rise;
    logic         out_rise;
    logic         out_fall;
    lgc_mode_type mode;

    assign mode     = lgc_mode_type'(cell_control_q[CTL_MODE_LSB +: CTL_MODE_W]);
    assign clk_rise = gate[0] & ~gate_one_prev_q;
    assign out_rise = result_q & ~result_prev_q;
    assign out_fall = ~result_q & result_prev_q;

    // Source multiplexers; reserved codes read low
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (int'(input_source_q[i]) < NUM_SRC) begin
                selected[i] = src_in[input_source_q[i]];
            end else begin
                selected[i] = 1'b0;
            end
        end
    end

    // Four identical gates
    for (genvar g = 0; g < 4; g++) begin : gen_gate
        lgc_gate u_gate (
            .data     (selected),
            .route    (gate_route_q[g]),
            .invert   (gate_invert_q[g]),
            .gate_out (gate[g])
        );
    end

    // Configuration writes; these survive rst on purpose
    always_comb begin
        input_source_d = input_source_q;
        gate_route_d   = gate_route_q;
        gate_invert_d  = gate_invert_q;
        if (bus_req.wr) begin
            for (int i = 0; i < 4; i++) begin
                if (bus_req.addr == OFS_SEL_ONE + 4'(i)) begin
                    input_source_d[i] = bus_req.wdata[SRC_W-1:0];
                end
                if (bus_req.addr == OFS_GLS_ONE + 4'(i)) begin
                    gate_route_d[i] = bus_req.wdata;
                end
            end
            if (bus_req.addr == OFS_POLARITY) begin
                gate_invert_d = bus_req.wdata[3:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        input_source_q <= input_source_d;
        gate_route_q   <= gate_route_d;
        gate_invert_q  <= gate_invert_d;
    end

    // Logic function; flop modes step on a rising gate one
    always_comb begin
        state_d = state_q;
        func    = 1'b0;
        case (mode)
            MODE_AND_OR: begin
                func = (gate[0] & gate[1]) | (gate[2] & gate[3]);
            end
            MODE_OR_XOR: begin
                func = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
            end
            MODE_AND4: begin
                func = &gate;
            end
            MODE_SR_LATCH: begin
                if (gate[0] | gate[1]) begin
                    state_d = 1'b1;
                end else if (gate[2] | gate[3]) begin
                    state_d = 1'b0;
                end
                func = state_d;
            end
            MODE_DFF_SR: begin
                if (gate[3]) begin
                    state_d = 1'b1;
                end else if (gate[2]) begin
                    state_d = 1'b0;
                end else if (clk_rise) begin
                    state_d = gate[1];
                end
                func = state_d;
            end
            MODE_DFF_R: begin
                // data is gate two xor four
                if (gate[2]) begin
                    state_d = 1'b0;
                end else if (clk_rise) begin
                    state_d = gate[1] ^ gate[3];
                end
                func = state_d;
            end
            MODE_JK_R: begin
                if (gate[2]) begin
                    state_d = 1'b0;
                end else if (clk_rise) begin
                    case ({gate[1], gate[3]})
                        2'b10:   state_d = 1'b1;
                        2'b01:   state_d = 1'b0;
                        2'b11:   state_d = ~state_q;
                        default: state_d = state_q;
                    endcase
                end
                func = state_d;
            end
            MODE_LATCH_SR: begin
                if (gate[3]) begin
                    state_d = 1'b1;
                end else if (gate[2]) begin
                    state_d = 1'b0;
                end else if (gate[0]) begin
                    state_d = gate[1];
                end
                func = state_d;
            end
            default: begin
                func = 1'b0;
            end
        endcase
    end

    // Control, output and flag; a polarity flip while enabled is an edge too
    always_comb begin
        cell_control_d  = cell_control_q;
        result_invert_d = result_invert_q;
        flag_d          = flag_q;
        if (bus_req.wr && bus_req.addr == OFS_CONTROL) begin
            cell_control_d = bus_req.wdata & 8'h9F;  // Readback and bit 6 not writable
        end
        if (bus_req.wr && bus_req.addr == OFS_POLARITY) begin
            result_invert_d = bus_req.wdata[POL_RESULT];
        end
        result_d = cell_control_q[CTL_ENABLE] ? (func ^ result_invert_q) : 1'b0;
        if (bus_req.wr && bus_req.addr == OFS_STATUS && !bus_req.wdata[STAT_FLAG]) begin
            flag_d = 1'b0;
        end
        if ((out_rise && cell_control_q[CTL_RISE_IE]) || (out_fall && cell_control_q[CTL_FALL_IE])) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cell_control_q  <= CONTROL_RESET;
            result_invert_q <= RESULT_INV_RESET;
            state_q         <= 1'b0;
            gate_one_prev_q <= 1'b0;
            result_q        <= 1'b0;
            result_prev_q   <= 1'b0;
            flag_q          <= 1'b0;
        end else begin
            cell_control_q  <= cell_control_d;
            result_invert_q <= result_invert_d;
            state_q         <= state_d;
            gate_one_prev_q <= gate[0];
            result_q        <= result_d;
            result_prev_q   <= result_q;
            flag_q          <= flag_d;
        end
    end

    // Read data, one cycle after the strobe, zero elsewhere
    always_comb begin
        rdata_d = 8'h00;
        if (bus_req.rd) begin
            if (bus_req.addr == OFS_CONTROL) begin
                rdata_d = cell_control_q;
                rdata_d[CTL_READBACK] = result_q;
            end else if (bus_req.addr == OFS_POLARITY) begin
                rdata_d = {result_invert_q, 3'b000, gate_invert_q};
            end else if (bus_req.addr >= OFS_SEL_ONE && bus_req.addr <= OFS_SEL_FOUR) begin
                rdata_d = {2'b00, input_source_q[2'(bus_req.addr - OFS_SEL_ONE)]};
            end else if (bus_req.addr >= OFS_GLS_ONE && bus_req.addr <= OFS_GLS_FOUR) begin
                rdata_d = gate_route_q[2'(bus_req.addr - OFS_GLS_ONE)];
            end else if (bus_req.addr == OFS_STATUS) begin
                rdata_d = {7'h00, flag_q};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata         = rdata_q;
    assign cell_result   = result_q;
    assign cell_irq_flag = flag_q;

    // Checks on the cell's own outputs
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_rise_sets_flag: assert property (out_rise && cell_control_q[CTL_RISE_IE] |=> flag_q)
        else $error("rising output did not set flag");
    a_fall_sets_flag: assert property (out_fall && cell_control_q[CTL_FALL_IE] |=> flag_q)
        else $error("falling output did not set flag");
    a_flag_has_cause: assert property (!flag_q ##1 flag_q |->
        $past((out_rise && cell_control_q[CTL_RISE_IE]) || (out_fall && cell_control_q[CTL_FALL_IE])))
        else $error("flag set without enabled edge");
    a_disabled_out_low: assert property (!cell_control_q[CTL_ENABLE] |=> !result_q)
        else $error("disabled cell output not low");
    a_reset_clears_ctl: assert property (@(posedge clk) disable iff (1'b0) rst
        |=> cell_control_q == CONTROL_RESET)
        else $error("control not cleared by reset");
    a_readback_output: assert property (bus_req.rd && bus_req.addr == OFS_CONTROL |=>
        rdata[CTL_READBACK] == $past(result_q))
        else $error("readback bit differs from output");
    a_sel_top_zero: assert property (bus_req.rd && bus_req.addr >= OFS_SEL_ONE && bus_req.addr <= OFS_SEL_FOUR
        |=> rdata[7:6] == 2'b00)
        else $error("select register top bits not zero");
    a_and_mode_out: assert property (cell_control_q[CTL_ENABLE] && mode == MODE_AND4
        |=> result_q == ($past(&gate) ^ $past(result_invert_q)))
        else $error("four-input and result wrong");
    a_dff_capture: assert property (cell_control_q[CTL_ENABLE] && mode == MODE_DFF_R && !gate[2] && clk_rise
        |=> result_q == ($past(gate[1] ^ gate[3]) ^ $past(result_invert_q)))
        else $error("two-input flop did not capture");
    a_dff_sr_set: assert property (cell_control_q[CTL_ENABLE] && mode == MODE_DFF_SR && gate[3]
        |=> result_q == !$past(result_invert_q))
        else $error("flop set input ignored");

    c_rise_flag: cover property (out_rise && cell_control_q[CTL_RISE_IE] ##1 flag_q);
    c_fall_flag: cover property (out_fall && cell_control_q[CTL_FALL_IE] ##1 flag_q);
    c_jk_toggle: cover property (mode == MODE_JK_R && clk_rise && gate[1] && gate[3]);
    c_clear_race: cover property (bus_req.wr && bus_req.addr == OFS_STATUS && out_rise);

endmodule

// file: verilog/lgc_pkg.sv
// Package for the configurable logic cell: register offsets, field positions,
// reset values, function codes and the register port carrier.
// Assumes an 8-bit register port with word-sized registers at small offsets.
package lgc_pkg;

    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [3:0] OFS_CONTROL  = 4'h0;
    localparam logic [3:0] OFS_POLARITY = 4'h1;
    localparam logic [3:0] OFS_SEL_ONE  = 4'h2;
    localparam logic [3:0] OFS_SEL_FOUR = 4'h5;
    localparam logic [3:0] OFS_GLS_ONE  = 4'h6;
    localparam logic [3:0] OFS_GLS_FOUR = 4'h9;
    localparam logic [3:0] OFS_STATUS   = 4'hA;

    // Control field positions
    localparam int CTL_ENABLE   = 7;
    localparam int CTL_READBACK = 5;
    localparam int CTL_RISE_IE  = 4;
    localparam int CTL_FALL_IE  = 3;
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_MODE_W   = 3;

    // Polarity field positions and status flag position
    localparam int POL_RESULT   = 7;
    localparam int STAT_FLAG    = 0;

    // Source select width and reset values
    localparam int SRC_W        = 6;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic       RESULT_INV_RESET = 1'b0;

    // Logic function codes
    typedef enum logic [2:0] {
        MODE_AND_OR   = 3'h0,
        MODE_OR_XOR   = 3'h1,
        MODE_AND4     = 3'h2,
        MODE_SR_LATCH = 3'h3,
        MODE_DFF_SR   = 3'h4,
        MODE_DFF_R    = 3'h5,
        MODE_JK_R     = 3'h6,
        MODE_LATCH_SR = 3'h7
    } lgc_mode_type;

    // One register access from software
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lgc_bus_req_type;

endpackage

// file: verilog/lgc_gate.sv
// One data gate: routes the four selected inputs true or inverted into an AND.
// Assumes the selected inputs are already synchronous to the register clock.
`timescale 1ns/10ps
module lgc_gate (
    input  wire logic [3:0] data,
    input  wire logic [7:0] route,
    input  wire logic       invert,
    output logic            gate_out
);

    logic term;
    logic hit;

    // Pair i: upper bit routes true, lower bit routes inverted
    always_comb begin
        term = 1'b1;
        hit  = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (route[2*i+1]) begin
                term = term & data[i];
                hit  = 1'b1;
            end
            if (route[2*i]) begin
                term = term & ~data[i];
                hit  = 1'b1;
            end
        end
        gate_out = (hit & term) ^ invert;
    end

endmodule

// file: sim/configurable_logic_cell_test.sv
// Self-checking bench for the configurable logic cell: reset and selects, then a
// table of cell setups, then edge flag, disable, source range and mid-run reset cases.
// Assumes lgc_pkg offsets and read data standing one cycle after the strobe.
`timescale 1ns/10ps
module configurable_logic_cell_test
    import lgc_pkg::*;
;
    localparam int          NR = 34;
    localparam logic [31:0] RT = 32'h8020_0802;   // Gate n takes input n true

    logic            clk = 1'b0;
    logic            rst = 1'b1;
    lgc_bus_req_type bus_req = '0;
    logic [7:0]      rdata;
    logic [39:0]     src_in = '0;
    logic            cell_result;
    logic            cell_irq_flag;
    int              err_total = 0;
    int              checks = 0;
    logic [7:0]      rv;

    // Row: gate routes, polarity, control, pins 4..1, expected output
    logic [52:0] rows [NR] = '{
        {RT, 8'h00, 8'h80, 4'h3, 1'h1}, {RT, 8'h00, 8'h80, 4'h5, 1'h0},
        {RT, 8'h00, 8'h81, 4'h1, 1'h1}, {RT, 8'h00, 8'h81, 4'h5, 1'h0},
        {RT, 8'h00, 8'h82, 4'hF, 1'h1}, {RT, 8'h80, 8'h82, 4'hF, 1'h0},
        {RT, 8'h08, 8'h82, 4'h7, 1'h1}, {32'h4010_0401, 8'h00, 8'h82, 4'h0, 1'h1},
        {32'h0000_0000, 8'h0F, 8'h82, 4'h0, 1'h1}, {32'h0000_0000, 8'h00, 8'h82, 4'hF, 1'h0},
        {32'h0000_0003, 8'h0E, 8'h82, 4'h1, 1'h0}, {32'h0000_0002, 8'h0E, 8'h82, 4'h1, 1'h1},
        {32'h0000_0002, 8'h0E, 8'h82, 4'hE, 1'h0},
        {RT, 8'h00, 8'h83, 4'h4, 1'h0}, {RT, 8'h00, 8'h83, 4'h1, 1'h1}, {RT, 8'h00, 8'h83, 4'h0, 1'h1},
        {RT, 8'h00, 8'h84, 4'h4, 1'h0}, {RT, 8'h00, 8'h84, 4'h8, 1'h1},
        {RT, 8'h00, 8'h84, 4'h0, 1'h1}, {RT, 8'h00, 8'h84, 4'h1, 1'h0},
        {RT, 8'h00, 8'h85, 4'h4, 1'h0}, {RT, 8'h00, 8'h85, 4'h8, 1'h0}, {RT, 8'h00, 8'h85, 4'h9, 1'h1},
        {RT, 8'h00, 8'h85, 4'hB, 1'h1}, {RT, 8'h00, 8'h85, 4'h4, 1'h0},
        {RT, 8'h00, 8'h86, 4'h4, 1'h0}, {RT, 8'h00, 8'h86, 4'h2, 1'h0}, {RT, 8'h00, 8'h86, 4'h3, 1'h1},
        {RT, 8'h00, 8'h86, 4'h8, 1'h1}, {RT, 8'h00, 8'h86, 4'h9, 1'h0},
        {RT, 8'h00, 8'h87, 4'h3, 1'h1}, {RT, 8'h00, 8'h87, 4'h1, 1'h0},
        {RT, 8'h00, 8'h87, 4'h2, 1'h0}, {RT, 8'h00, 8'h87, 4'h8, 1'h1}};

    lgc_cell #(.NUM_SRC(40)) dut_u (
        .clk           (clk),
        .rst           (rst),
        .bus_req       (bus_req),
        .rdata         (rdata),
        .src_in        (src_in),
        .cell_result   (cell_result),
        .cell_irq_flag (cell_irq_flag)
    );

    // 20 MHz clock
    always #25 clk = ~clk;

    // One-cycle write strobe, dropped at the edge that takes it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 rv = rdata;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Wait past the edges so registered outputs have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Output lags sources by one cycle, flag by one more
    task automatic drive(input logic [39:0] s);
        @(posedge clk);
        src_in <= s;
        settle(3);
    endtask

    task automatic setup(input logic [31:0] r, input logic [7:0] p, input logic [7:0] c);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_GLS_ONE + 4'(i), r[8*i +: 8]);
        end
        wr(OFS_POLARITY, p);
        wr(OFS_CONTROL, c);
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_CONTROL);
        check(rv, 8'h00);
        rd(OFS_POLARITY);
        check(rv & 8'h80, 8'h00);
        rd(4'hB);
        check(rv, 8'h00);
        check({7'h00, cell_irq_flag}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_SEL_ONE + 4'(i), 8'hC0 | 8'(i));
            rd(OFS_SEL_ONE + 4'(i));
            check(rv, 8'(i));
        end
        $display("test reset and selects done");
        // Table of gate, polarity and function setups
        foreach (rows[n]) begin
            setup(rows[n][52:21], rows[n][20:13], rows[n][12:5]);
            drive({36'h0_0000_0000, rows[n][4:1]});
            check({7'h00, cell_result}, {7'h00, rows[n][0]});
            rd(OFS_CONTROL);
            check(rv, rows[n][12:5] | {2'h0, rows[n][0], 5'h00});
        end
        $display("test function table done");
        // Output follows input one alone
        setup(32'h0000_0002, 8'h0E, 8'h92);
        drive(40'h00_0000_0000);
        wr(OFS_STATUS, 8'h00);
        drive(40'h00_0000_0001);
        check({7'h00, cell_irq_flag}, 8'h01);
        wr(OFS_STATUS, 8'h00);
        drive(40'h00_0000_0000);
        check({7'h00, cell_irq_flag}, 8'h00);
        wr(OFS_CONTROL, 8'h8A);
        drive(40'h00_0000_0001);
        check({7'h00, cell_irq_flag}, 8'h00);
        drive(40'h00_0000_0000);
        rd(OFS_STATUS);
        check(rv, 8'h01);
        wr(OFS_STATUS, 8'h01);
        rd(OFS_STATUS);
        check(rv, 8'h01);
        // Rising edge lands on the clearing write
        wr(OFS_STATUS, 8'h00);
        wr(OFS_CONTROL, 8'h92);
        @(posedge clk);
        src_in <= 40'h00_0000_0001;
        wr(OFS_STATUS, 8'h00);
        settle(2);
        check({7'h00, cell_irq_flag}, 8'h01);
        // Disabling drops the output, a falling edge
        wr(OFS_STATUS, 8'h00);
        wr(OFS_CONTROL, 8'h0A);
        settle(3);
        check({7'h00, cell_result}, 8'h00);
        check({7'h00, cell_irq_flag}, 8'h01);
        $display("test edge flag done");
        // Highest defined source, then first reserved code
        wr(OFS_CONTROL, 8'h82);
        wr(OFS_SEL_ONE, 8'h27);
        drive(40'h80_0000_0000);
        check({7'h00, cell_result}, 8'h01);
        wr(OFS_SEL_ONE, 8'h28);
        drive('1);
        check({7'h00, cell_result}, 8'h00);
        wr(OFS_CONTROL, 8'hE2);
        rd(OFS_CONTROL);
        check(rv, 8'h82);
        $display("test source range done");
        // Reset in mid-run keeps selection and gating
        wr(OFS_POLARITY, 8'h8E);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_CONTROL);
        check(rv, 8'h00);
        rd(OFS_POLARITY);
        check(rv, 8'h0E);
        rd(OFS_SEL_ONE);
        check(rv, 8'h28);
        rd(OFS_GLS_ONE);
        check(rv, 8'h02);
        check({6'h00, cell_result, cell_irq_flag}, 8'h00);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule
